// *** shared/rtc_defs.vh ***
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// ----------------------------------------
// command byte fields
// ----------------------------------------
`define RTC_CMD_RD_BIT 0
`define RTC_CMD_ADDR_LSB 1
`define RTC_CMD_ADDR_MSB 5
`define RTC_CMD_SPACE_BIT 6
`define RTC_CMD_VALID_BIT 7
`define RTC_BURST_ADDR 5'h1F

// ----------------------------------------
// address map and sizes
// ----------------------------------------
`define RTC_CAL_REGS 5'h08
`define RTC_RAM_WORDS 5'h1F
`define RTC_A_SEC 5'h00
`define RTC_A_MIN 5'h01
`define RTC_A_HOUR 5'h02
`define RTC_A_DATE 5'h03
`define RTC_A_MONTH 5'h04
`define RTC_A_DAY 5'h05
`define RTC_A_YEAR 5'h06
`define RTC_A_CTRL 5'h07

// ----------------------------------------
// register fields
// ----------------------------------------
`define RTC_HALT_BIT 7
`define RTC_H12_BIT 7
`define RTC_PM_BIT 5
`define RTC_WP_BIT 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define RTC_RST_ZERO 8'h00
`define RTC_RST_ONE 8'h01

// ----------------------------------------
// timing
// ----------------------------------------
`define RTC_TB_FREQ_HZ 32768

`endif

// *** hw/rtc_serial.v ***
`timescale 1ns/1ps
`include "rtc_defs.vh"

// How it works
// - command bit 7 low blocks writes
// - bit 6 picks calendar or RAM
// - bits 1..5 give register address
// - bit 0: zero write, one read
// - command assembled LSB first
// - first eight bits after enable are command
// - enable high runs control and shifter
// - enable low aborts, data line released
// - bit period is fall then rise
// - sample on rise, drive on fall
// - write byte captured over next eight rises
// - extra single-write cycles are ignored
// - write data assembled from bit 0
// - single byte or burst up to 31
// - counts seconds through year, readable serially
// - date wraps at real month length
// - 24-hour or 12-hour with PM flag
// - every fourth year is leap
// - 31 bytes of scratch RAM
// - timekeeping runs from 32.768kHz timebase
// - read bits driven on falls, bit 0 first
// - data line released on each rise
// - enable held keeps read burst going
// - address 31 selects burst from 0
module rtc_serial #(
  parameter TB_DIV = `RTC_TB_FREQ_HZ,
  parameter BUF_W = 14
) (
  // system
  input wire clk,
  input wire resetn,
  // serial link
  input wire ce_pin,
  input wire sclk_pin,
  input wire dio_in,
  output reg dio_out_ff,
  output reg dio_oe_ff,
  // timebase
  input wire timebase_input_pin,
  output reg timebase_output_pin_ff,
  // status
  output reg write_protect_ff,
  output reg clock_halted_ff
);

  localparam PH_CMD = 2'b00, PH_WR = 2'b01, PH_RD = 2'b10, PH_DONE = 2'b11;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [7:0] bcd_inc;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if (v >= hi)
        bcd_inc = lo;
      else if (v[3:0] >= 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function [7:0] last_date;
    input [7:0] mo;
    input [7:0] yr;
    reg leap;
    begin
      leap = (~yr[4] & (yr[3:0] == 4'h0 | yr[3:0] == 4'h4 | yr[3:0] == 4'h8)) |
             (yr[4] & (yr[3:0] == 4'h2 | yr[3:0] == 4'h6));
      case (mo)
        8'h02: last_date = leap ? 8'h29 : 8'h28;
        8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
        default: last_date = 8'h31;
      endcase
    end
  endfunction

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  reg ce_s1_ff, ce_s2_ff, sclk_s1_ff, sclk_s2_ff, sclk_d_ff, dio_s1_ff, dio_s2_ff, tb_s1_ff, tb_s2_ff, tb_d_ff;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {ce_s1_ff, ce_s2_ff, sclk_s1_ff, sclk_s2_ff, sclk_d_ff} <= 5'h00;
      {dio_s1_ff, dio_s2_ff, tb_s1_ff, tb_s2_ff, tb_d_ff} <= 5'h00;
      timebase_output_pin_ff <= 1'b1;
    end else begin
      {ce_s1_ff, sclk_s1_ff, dio_s1_ff, tb_s1_ff} <= {ce_pin, sclk_pin, dio_in, timebase_input_pin};
      {ce_s2_ff, sclk_s2_ff, dio_s2_ff, tb_s2_ff} <= {ce_s1_ff, sclk_s1_ff, dio_s1_ff, tb_s1_ff};
      {sclk_d_ff, tb_d_ff} <= {sclk_s2_ff, tb_s2_ff};
      timebase_output_pin_ff <= ~tb_s2_ff;
    end
  end

  wire sclk_rise = sclk_s2_ff & ~sclk_d_ff, sclk_fall = ~sclk_s2_ff & sclk_d_ff, tb_rise = tb_s2_ff & ~tb_d_ff;

  // ----------------------------------------
  // one-second prescaler
  // ----------------------------------------
  reg [15:0] pre_ff;
  reg tick_ff;
  reg [7:0] sec_ff, min_ff, hour_ff, date_ff, month_ff, day_ff, year_ff, ctrl_ff;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {pre_ff, tick_ff} <= 17'h00000;
    end else begin
      tick_ff <= 1'b0;
      if (tb_rise && !sec_ff[`RTC_HALT_BIT]) begin
        if (pre_ff == TB_DIV - 1) begin
          pre_ff <= 16'h0000;
          tick_ff <= 1'b1;
        end else
          pre_ff <= pre_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // write buffer (drain stalls on tick)
  // ----------------------------------------
  reg [BUF_W-1:0] buf_ff [0:1];
  reg buf_wp_ff, buf_rp_ff;
  reg [1:0] buf_cnt_ff;
  reg push;
  reg [BUF_W-1:0] push_data;
  wire buf_in_ready = (buf_cnt_ff != 2'b10);
  wire buf_out_valid = (buf_cnt_ff != 2'b00);
  wire buf_out_ready = ~tick_ff;
  wire do_push = push & buf_in_ready;
  wire do_pop = buf_out_valid & buf_out_ready;
  wire [BUF_W-1:0] pop_data = buf_ff[buf_rp_ff];
  wire pop_ram = pop_data[13];
  wire [4:0] pop_addr = pop_data[12:8];
  wire [7:0] pop_byte = pop_data[7:0];

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {buf_wp_ff, buf_rp_ff, buf_cnt_ff} <= 4'h0;
      buf_ff[0] <= {BUF_W{1'b0}};
      buf_ff[1] <= {BUF_W{1'b0}};
    end else begin
      if (do_push) begin
        buf_ff[buf_wp_ff] <= push_data;
        buf_wp_ff <= ~buf_wp_ff;
      end
      if (do_pop)
        buf_rp_ff <= ~buf_rp_ff;
      if (do_push && !do_pop)
        buf_cnt_ff <= buf_cnt_ff + 2'b01;
      else if (do_pop && !do_push)
        buf_cnt_ff <= buf_cnt_ff - 2'b01;
    end
  end

  // ----------------------------------------
  // scratch RAM
  // ----------------------------------------
  reg [7:0] ram [0:30];
  wire wp = ctrl_ff[`RTC_WP_BIT];

  always @(posedge clk) begin
    if (do_pop && pop_ram && pop_addr < `RTC_RAM_WORDS && !wp)
      ram[pop_addr] <= pop_byte;
  end

  // ----------------------------------------
  // calendar
  // ----------------------------------------
  wire h12 = hour_ff[`RTC_H12_BIT];
  wire sec_c = (sec_ff[6:0] == 7'h59);
  wire min_c = sec_c & (min_ff == 8'h59);
  wire hr_c = min_c & (h12 ? (hour_ff[`RTC_PM_BIT] & hour_ff[4:0] == 5'h11) : (hour_ff[5:0] == 6'h23));
  wire date_c = hr_c & (date_ff == last_date(month_ff, year_ff));
  wire mon_c = date_c & (month_ff == 8'h12);
  reg [7:0] nxt_hour;
  wire [7:0] sec_inc = bcd_inc({1'b0, sec_ff[6:0]}, 8'h00, 8'h59);
  wire [7:0] h12_inc = bcd_inc({3'b000, hour_ff[4:0]}, 8'h01, 8'h12);
  wire [7:0] h24_inc = bcd_inc({2'b00, hour_ff[5:0]}, 8'h00, 8'h23);
  wire cal_wr = do_pop & ~pop_ram & (~wp | pop_addr == `RTC_A_CTRL);

  always @* begin
    nxt_hour = hour_ff;
    if (h12) begin
      if (hour_ff[4:0] == 5'h12)
        nxt_hour = {hour_ff[7:5], 5'h01};
      else if (hour_ff[4:0] == 5'h11)
        nxt_hour = {hour_ff[7:6], ~hour_ff[`RTC_PM_BIT], 5'h12};
      else
        nxt_hour = {hour_ff[7:5], h12_inc[4:0]};
    end else
      nxt_hour = {hour_ff[7:6], h24_inc[5:0]};
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {sec_ff, min_ff, hour_ff, year_ff, ctrl_ff} <= {5{`RTC_RST_ZERO}};
      {date_ff, month_ff, day_ff} <= {3{`RTC_RST_ONE}};
    end else if (tick_ff) begin
      sec_ff <= {sec_ff[7], sec_inc[6:0]};
      if (sec_c)
        min_ff <= bcd_inc(min_ff, 8'h00, 8'h59);
      if (min_c)
        hour_ff <= nxt_hour;
      if (hr_c) begin
        day_ff <= bcd_inc(day_ff, 8'h01, 8'h07);
        date_ff <= bcd_inc(date_ff, 8'h01, last_date(month_ff, year_ff));
      end
      if (date_c)
        month_ff <= bcd_inc(month_ff, 8'h01, 8'h12);
      if (mon_c)
        year_ff <= bcd_inc(year_ff, 8'h00, 8'h99);
    end else if (cal_wr) begin
      case (pop_addr)
        `RTC_A_SEC: sec_ff <= pop_byte;
        `RTC_A_MIN: min_ff <= pop_byte;
        `RTC_A_HOUR: hour_ff <= pop_byte;
        `RTC_A_DATE: date_ff <= pop_byte;
        `RTC_A_MONTH: month_ff <= pop_byte;
        `RTC_A_DAY: day_ff <= pop_byte;
        `RTC_A_YEAR: year_ff <= pop_byte;
        `RTC_A_CTRL: ctrl_ff <= {pop_byte[`RTC_WP_BIT], 7'h00};
        default: ;
      endcase
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      {write_protect_ff, clock_halted_ff} <= 2'h0;
    else
      {write_protect_ff, clock_halted_ff} <= {wp, sec_ff[`RTC_HALT_BIT]};
  end

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  reg [1:0] phase_ff;
  reg [2:0] bit_ff;
  reg [7:0] sr_ff;
  reg [7:0] out_sr_ff;
  reg ram_sel_ff, burst_ff;
  reg [4:0] addr_ff;
  reg [7:0] rd_byte;
  wire [7:0] nxt_sr = {dio_s2_ff, sr_ff[7:1]};
  wire [4:0] lim = ram_sel_ff ? `RTC_RAM_WORDS : `RTC_CAL_REGS;
  // first fall of each byte loads it fresh, later falls shift
  wire [7:0] out_src = (bit_ff == 3'h0) ? rd_byte : out_sr_ff;

  always @* begin
    rd_byte = 8'h00;
    if (ram_sel_ff) begin
      if (addr_ff < `RTC_RAM_WORDS)
        rd_byte = ram[addr_ff];
    end else begin
      case (addr_ff)
        `RTC_A_SEC: rd_byte = sec_ff;
        `RTC_A_MIN: rd_byte = min_ff;
        `RTC_A_HOUR: rd_byte = hour_ff;
        `RTC_A_DATE: rd_byte = date_ff;
        `RTC_A_MONTH: rd_byte = month_ff;
        `RTC_A_DAY: rd_byte = day_ff;
        `RTC_A_YEAR: rd_byte = year_ff;
        `RTC_A_CTRL: rd_byte = ctrl_ff;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // host keeps the shift clock low when enabling, so no stale edge is seen
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_ff <= PH_CMD;
      {bit_ff, sr_ff, out_sr_ff, ram_sel_ff, burst_ff, addr_ff, dio_out_ff, dio_oe_ff, push} <= 29'h0000000;
      push_data <= {BUF_W{1'b0}};
    end else begin
      push <= 1'b0;
      if (!ce_s2_ff) begin
        phase_ff <= PH_CMD;
        bit_ff <= 3'h0;
        dio_oe_ff <= 1'b0;
      end else if (sclk_rise) begin
        dio_oe_ff <= 1'b0;
        case (phase_ff)
          PH_CMD: begin
            sr_ff <= nxt_sr;
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              ram_sel_ff <= nxt_sr[`RTC_CMD_SPACE_BIT];
              burst_ff <= (nxt_sr[5:1] == `RTC_BURST_ADDR);
              addr_ff <= (nxt_sr[5:1] == `RTC_BURST_ADDR) ? 5'h00 :
                         nxt_sr[`RTC_CMD_ADDR_MSB:`RTC_CMD_ADDR_LSB];
              if (nxt_sr[`RTC_CMD_RD_BIT])
                phase_ff <= PH_RD;
              else if (nxt_sr[`RTC_CMD_VALID_BIT])
                phase_ff <= PH_WR;
              else
                phase_ff <= PH_DONE;
            end
          end
          PH_WR: begin
            sr_ff <= nxt_sr;
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              push <= 1'b1;
              push_data <= {ram_sel_ff, addr_ff, nxt_sr};
              if (burst_ff && addr_ff + 5'h01 < lim)
                addr_ff <= addr_ff + 5'h01;
              else
                phase_ff <= PH_DONE;
            end
          end
          default: ;
        endcase
      end else if (sclk_fall && phase_ff == PH_RD) begin
        dio_oe_ff <= 1'b1;
        bit_ff <= bit_ff + 3'h1;
        dio_out_ff <= out_src[0];
        out_sr_ff <= {1'b0, out_src[7:1]};
        if (bit_ff == 3'h7 && burst_ff)
          addr_ff <= (addr_ff + 5'h01 < lim) ? addr_ff + 5'h01 : 5'h00;
      end
    end
  end

endmodule

// *** verif/rtc_hm.sv ***
`timescale 1ns/1ps
module rtc_hm (
  // system
  input wire clk,
  // link, host side
  input wire dio_pin,
  output reg ce,
  output reg sclk,
  output reg dio_drv,
  output reg dio_oe
);
  initial begin
    ce = 0;
    sclk = 0;
    dio_drv = 0;
    dio_oe = 0;
  end
  // ------
  // one bit: fall, 4 clk, rise, 3 clk
  // ------
  task shift(input logic wr, input logic b, output logic r);
    @(negedge clk);
    sclk = 0;
    dio_oe = wr;
    dio_drv = b;
    repeat (4) @(negedge clk);
    r = dio_pin;
    sclk = 1;
    repeat (3) @(negedge clk);
  endtask
  task put(input logic [7:0] v);
    logic r;
    for (int i = 0; i < 8; i++) shift(1, v[i], r);
  endtask
  task get(output logic [7:0] v);
    for (int i = 0; i < 8; i++) shift(0, 0, v[i]);
  endtask
  task sel;
    @(negedge clk);
    sclk = 0;
    ce = 1;
  endtask
  // clock left high until enable is seen low, so no stray fall
  task desel;
    @(negedge clk);
    ce = 0;
    dio_oe = 0;
    repeat (4) @(negedge clk);
    sclk = 0;
  endtask
endmodule

// *** verif/rtc_serial_props.sv ***
`timescale 1ns/1ps
module rtc_serial_chk (
  // system
  input wire clk,
  input wire resetn,
  // link
  input wire ce_pin,
  input wire sclk_pin,
  input wire dio_out_ff,
  input wire dio_oe_ff,
  // timebase, status
  input wire timebase_input_pin,
  input wire timebase_output_pin_ff,
  input wire write_protect_ff,
  input wire clock_halted_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ce_low_release_a: assert property (!ce_pin [*5] |-> !dio_oe_ff)
    else $error("data line driven with enable low");
  rise_release_a: assert property ($rose(sclk_pin) |-> ##[1:5] !dio_oe_ff)
    else $error("data line not released after clock rise");
  drive_on_fall_a: assert property ($rose(dio_oe_ff) |-> !sclk_pin && ce_pin)
    else $error("data driven outside low clock phase");
  bit_steady_a: assert property (dio_oe_ff && $past(dio_oe_ff) |-> $stable(dio_out_ff))
    else $error("driven bit changed mid phase");
  tb_high_a: assert property (timebase_input_pin [*5] |-> !timebase_output_pin_ff)
    else $error("timebase feedback not inverted");
  tb_low_a: assert property (!timebase_input_pin [*5] |-> timebase_output_pin_ff)
    else $error("timebase feedback not inverted");
  wp_idle_a: assert property (!ce_pin [*8] |=> $stable(write_protect_ff))
    else $error("protect bit changed while idle");
  halt_idle_a: assert property (!ce_pin [*8] |=> $stable(clock_halted_ff))
    else $error("halt bit changed while idle");
endmodule
bind rtc_serial rtc_serial_chk u_chk (.clk(clk), .resetn(resetn), .ce_pin(ce_pin), .sclk_pin(sclk_pin),
  .dio_out_ff(dio_out_ff), .dio_oe_ff(dio_oe_ff), .timebase_input_pin(timebase_input_pin),
  .timebase_output_pin_ff(timebase_output_pin_ff), .write_protect_ff(write_protect_ff),
  .clock_halted_ff(clock_halted_ff));

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic clk, resetn, tb_pin, dio_pin, r;
  wire dio_out_ff, dio_oe_ff, tb_out, wp, halted, ce, sclk, h_drv, h_oe;
  integer error_cnt = 0, compares = 0, cyc = 0, tcnt = 0, a;
  logic [31:0] seed = 32'h00002AEE;
  logic [7:0] ram_m [0:30];
  logic [7:0] q [$];
  logic [7:0] rd, d;
  // released line falls to its pull-down
  assign dio_pin = dio_oe_ff ? dio_out_ff : (h_oe ? h_drv : 1'b0);
  rtc_serial #(.TB_DIV(4)) u_rtc_serial (.clk(clk), .resetn(resetn), .ce_pin(ce), .sclk_pin(sclk),
    .dio_in(dio_pin), .dio_out_ff(dio_out_ff), .dio_oe_ff(dio_oe_ff), .timebase_input_pin(tb_pin),
    .timebase_output_pin_ff(tb_out), .write_protect_ff(wp), .clock_halted_ff(halted));
  rtc_hm u_rtc_hm (.clk(clk), .dio_pin(dio_pin), .ce(ce), .sclk(sclk), .dio_drv(h_drv), .dio_oe(h_oe));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // timebase near 32.768 kHz: 610 clk per period
  always @(negedge clk) begin
    tcnt <= (tcnt == 304) ? 0 : tcnt + 1;
    if (tcnt == 304) tb_pin <= ~tb_pin;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] cmdb(input logic ram, input logic [4:0] ad, input logic rdb);
    return {1'b1, ram, ad, rdb};
  endfunction
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task wr1(input logic [7:0] cmd, input logic [7:0] v);
    u_rtc_hm.sel();
    u_rtc_hm.put(cmd);
    u_rtc_hm.put(v);
    u_rtc_hm.desel();
  endtask
  task rd1(input logic [7:0] cmd, output logic [7:0] v);
    u_rtc_hm.sel();
    u_rtc_hm.put(cmd);
    u_rtc_hm.get(v);
    u_rtc_hm.desel();
  endtask
  // ------
  // calendar: set a day's last second, let one tick land
  // ------
  task cal_case(input logic [7:0] hr, dt, mo, dw, yr, ehr, edt, emo, edw);
    wr1(cmdb(0, 5'h1F, 0), 8'hD9);
    q = {8'h59, hr, dt, mo, dw, yr, 8'h00};
    u_rtc_hm.sel();
    u_rtc_hm.put(cmdb(0, 5'h1F, 0));
    u_rtc_hm.put(8'hD9);
    foreach (q[i]) u_rtc_hm.put(q[i]);
    u_rtc_hm.desel();
    chk("halt_set", halted, 8'h01);
    wr1(cmdb(0, 5'h00, 0), 8'h59);
    chk("halt_clr", halted, 8'h00);
    // poll until 59 rolls over; the next tick is at most four timebase periods off
    rd = 8'hFF;
    for (a = 0; a < 40 && rd !== 8'h00; a = a + 1)
      rd1(cmdb(0, 5'h00, 1), rd);
    q = {8'h00, 8'h00, ehr, edt, emo, edw, yr, 8'h00};
    u_rtc_hm.sel();
    u_rtc_hm.put(cmdb(0, 5'h1F, 1));
    foreach (q[i]) begin
      u_rtc_hm.get(rd);
      chk("cal", rd, q[i]);
    end
    u_rtc_hm.desel();
  endtask
  initial begin
    resetn = 0;
    tb_pin = 0;
    repeat (6) @(negedge clk);
    resetn = 1;
    repeat (2) @(negedge clk);
    chk("wp_rst", wp, 8'h00);
    u_rtc_hm.sel();
    u_rtc_hm.put(cmdb(1, 5'h1F, 0));
    for (a = 0; a < 31; a = a + 1) begin
      ram_m[a] = rnd();
      u_rtc_hm.put(ram_m[a]);
    end
    u_rtc_hm.desel();
    u_rtc_hm.sel();
    u_rtc_hm.put(cmdb(1, 5'h1F, 1));
    for (a = 0; a < 32; a = a + 1) begin
      u_rtc_hm.get(rd);
      chk("ram_burst", rd, ram_m[a % 31]);
    end
    u_rtc_hm.desel();
    rd1(cmdb(0, 5'h03, 1), rd);
    chk("date_rst", rd, 8'h01);
    for (a = 0; a < 31; a = a + 6) begin
      d = rnd();
      wr1(cmdb(1, a[4:0], 0), d);
      ram_m[a] = d;
      rd1(cmdb(1, a[4:0], 1), rd);
      chk("ram_single", rd, ram_m[a]);
    end
    wr1(cmdb(0, 5'h07, 0), 8'h80);
    chk("wp_set", wp, 8'h01);
    wr1(cmdb(1, 5'h0C, 0), ~ram_m[12]);
    rd1(cmdb(1, 5'h0C, 1), rd);
    chk("wp_block", rd, ram_m[12]);
    wr1(cmdb(0, 5'h07, 0), 8'h00);
    chk("wp_clr", wp, 8'h00);
    wr1(cmdb(1, 5'h02, 0) & 8'h7F, ~ram_m[2]);
    rd1(cmdb(1, 5'h02, 1), rd);
    chk("no_write", rd, ram_m[2]);
    d = rnd();
    u_rtc_hm.sel();
    u_rtc_hm.put(cmdb(1, 5'h05, 0));
    u_rtc_hm.put(d);
    u_rtc_hm.put(~d);
    u_rtc_hm.desel();
    ram_m[5] = d;
    u_rtc_hm.sel();
    u_rtc_hm.put(cmdb(1, 5'h07, 0));
    repeat (4) u_rtc_hm.shift(1, 1'b1, r);
    u_rtc_hm.desel();
    for (a = 5; a < 9; a = a + 1) begin
      rd1(cmdb(1, a[4:0], 1), rd);
      chk("ram_edge", rd, ram_m[a]);
    end
    cal_case(8'hB1, 8'h28, 8'h02, 8'h07, 8'h04, 8'h92, 8'h29, 8'h02, 8'h01);
    cal_case(8'h23, 8'h28, 8'h02, 8'h03, 8'h03, 8'h00, 8'h01, 8'h03, 8'h04);
    report_and_stop;
  end
endmodule
